// *** logic/pmd_decoder.sv ***
// Paged memory address decoder with run-time placement control.
// Assumes address, page and strobes are synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module pmd_decoder
(
  input  wire logic                        core_clk,              // 20 MHz
  input  wire logic                        rst,                   // Sync, high
  input  wire logic [pmd_pkg::ADDR_W-1:0]  addr,                  // Bus addr
  input  wire logic [pmd_pkg::PAGE_W-1:0]  page,                  // Page value
  input  wire logic                        program_fetch_strobe,  // Fetch
  input  wire logic                        data_rd_strobe,        // Data read
  input  wire logic                        data_wr_strobe,        // Data write
  input  wire logic                        placement_wr,          // Load ctl
  input  wire logic [pmd_pkg::PLACE_W-1:0] placement_wdata,       // New ctl
  output logic [pmd_pkg::PLACE_W-1:0]      memory_placement_control, // Ctl
  output logic [pmd_pkg::MF_SECTORS-1:0]   main_flash_sector_sel, // Sectors
  output logic [pmd_pkg::BF_SEGMENTS-1:0]  boot_flash_segment_sel, // Segs
  output logic                             sram_sel,              // SRAM
  output logic                             ctrl_block_sel         // Ctl block
);

  logic [pmd_pkg::PLACE_W-1:0]     placement_ff;
  logic                            fetch_cycle;
  logic                            data_cycle;
  logic [pmd_pkg::MF_SECTORS-1:0]  mf_hit;
  logic [pmd_pkg::BF_SEGMENTS-1:0] bf_hit;
  logic                            mf_ok;
  logic                            bf_ok;
  logic                            sram_ok;
  logic                            sram_win;
  logic                            ctrl_win;
  logic                            bf_any;
  logic                            top_pri;

  // Placement register; reloads its default on every reset
  always_ff @(posedge core_clk)
  begin
    if (rst)
      placement_ff <= pmd_pkg::PLC_RESET;
    else if (placement_wr)
      placement_ff <= placement_wdata;
  end

  assign memory_placement_control = placement_ff;

  // Access space qualifiers
  assign fetch_cycle = program_fetch_strobe;
  assign data_cycle  = data_rd_strobe | data_wr_strobe;

  // Which memories the current strobe may reach
  assign mf_ok = (fetch_cycle & placement_ff[pmd_pkg::PLC_MF_PROG]) |
    (data_cycle & placement_ff[pmd_pkg::PLC_MF_DATA]);
  assign bf_ok = (fetch_cycle & placement_ff[pmd_pkg::PLC_BF_PROG]) |
    (data_cycle & placement_ff[pmd_pkg::PLC_BF_DATA]);
  // SRAM always sits in data space; program space is optional
  assign sram_ok = data_cycle |
                   (fetch_cycle & placement_ff[pmd_pkg::PLC_SRAM_PROG]);

  // Main-flash sector windows; lower two are common, rest are paged
  genvar gi;
  generate
    for (gi = 0; gi < pmd_pkg::MF_SECTORS; gi++)
    begin : g_mf
      localparam bit          COMMON = gi < pmd_pkg::MF_COMMON;
      localparam logic [15:0] LO = COMMON ?
        16'(gi * pmd_pkg::MF_SECT_SIZE) :
        16'(pmd_pkg::MF_PAGE_BASE +
            ((gi - pmd_pkg::MF_COMMON) % 2) * pmd_pkg::MF_SECT_SIZE);
      localparam logic [15:0] HI = 16'(LO + pmd_pkg::MF_SECT_SIZE - 1);
      localparam logic [7:0]  PG = 8'((gi - pmd_pkg::MF_COMMON) / 2);
      assign mf_hit[gi] = (addr >= LO) && (addr <= HI) &&
                          (COMMON || (page == PG));
    end
    // Boot-flash segment windows, page ignored
    for (gi = 0; gi < pmd_pkg::BF_SEGMENTS; gi++)
    begin : g_bf
      localparam logic [15:0] LO =
        16'(pmd_pkg::BF_BASE + gi * pmd_pkg::BF_SEG_SIZE);
      localparam logic [15:0] HI = 16'(LO + pmd_pkg::BF_SEG_SIZE - 1);
      assign bf_hit[gi] = (addr >= LO) && (addr <= HI);
    end
  endgenerate

  // SRAM and control windows; no hole for processor-internal space
  assign sram_win = (addr >= pmd_pkg::SRAM_LO) &&
                    (addr <= pmd_pkg::SRAM_HI);
  assign ctrl_win = (addr >= pmd_pkg::CTRL_LO) &&
                    (addr <= pmd_pkg::CTRL_HI);

  // Priority resolution, all in the same bus cycle
  assign bf_any  = bf_ok & (|bf_hit);
  assign top_pri = sram_sel | ctrl_block_sel;
  assign sram_sel               = sram_ok & sram_win;
  assign ctrl_block_sel         = data_cycle & ctrl_win;
  assign boot_flash_segment_sel = (bf_ok & ~top_pri) ?
                                  bf_hit : '0;
  assign main_flash_sector_sel  = (mf_ok & ~top_pri & ~bf_any) ?
                                  mf_hit : '0;

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_sector_onehot: assert property ($onehot0(main_flash_sector_sel))
    else $error("more than one main-flash sector selected");
  a_boot_window: assert property (
    |boot_flash_segment_sel |-> addr[15] &&
      $onehot(boot_flash_segment_sel) &&
      boot_flash_segment_sel[addr[14:13]])
    else $error("boot segment select outside its window");
  a_ctrl_data: assert property (
    ctrl_block_sel |-> data_cycle && addr >= pmd_pkg::CTRL_LO &&
      addr <= pmd_pkg::CTRL_HI)
    else $error("control block selected outside data window");
  a_common_page: assert property (
    fetch_cycle && !data_cycle && placement_ff == pmd_pkg::PLC_RESET &&
      !addr[15] && addr > pmd_pkg::CTRL_HI
    |-> main_flash_sector_sel == (addr[14] ? 8'h02 : 8'h01))
    else $error("common sector decode wrong");
  a_paged_upper: assert property (
    fetch_cycle && !data_cycle && placement_ff == pmd_pkg::PLC_RESET &&
      page == 8'h01 && addr[15:14] == 2'h3
    |-> main_flash_sector_sel == 8'h20)
    else $error("paged sector decode wrong");
  a_boot_wins: assert property (
    |boot_flash_segment_sel |-> main_flash_sector_sel == '0)
    else $error("main flash selected over boot flash");
  a_sram_low: assert property (
    data_cycle && addr <= pmd_pkg::SRAM_HI
    |-> sram_sel && boot_flash_segment_sel == '0)
    else $error("SRAM not selected in its data window");
  a_idle_quiet: assert property (
    !fetch_cycle && !data_cycle |-> !sram_sel && !ctrl_block_sel &&
      main_flash_sector_sel == '0 && boot_flash_segment_sel == '0)
    else $error("select active with no strobe");
  a_place_hold: assert property (
    !placement_wr |=> placement_ff == $past(placement_ff))
    else $error("placement changed without a write");
  a_same_cycle: assert property (
    data_cycle && !fetch_cycle && placement_ff[pmd_pkg::PLC_BF_DATA] &&
      addr[15:13] == 3'h5 |-> boot_flash_segment_sel == 4'h2)
    else $error("boot select not valid in the same cycle");

  c_paged_fetch: cover property (fetch_cycle && main_flash_sector_sel[7]);
  c_boot_data:   cover property (data_cycle && boot_flash_segment_sel[3]);
  c_ctrl_access: cover property (ctrl_block_sel ##1 placement_wr);
  c_sram_fetch:  cover property (fetch_cycle && sram_sel);
  c_boot_fetch:  cover property (fetch_cycle && |boot_flash_segment_sel);

  // Boot segments never overlap each other
  a_boot_onehot: assert property ($onehot0(boot_flash_segment_sel))
    else $error("more than one boot segment selected");

  // Control block lives in data space only, whatever the placement
  a_ctrl_no_fetch: assert property (
    fetch_cycle && !data_cycle |-> !ctrl_block_sel)
    else $error("control block selected on a fetch");

  // SRAM outranks every flash select
  a_sram_over: assert property (
    sram_sel |-> main_flash_sector_sel == '0 &&
      boot_flash_segment_sel == '0)
    else $error("flash selected over SRAM");

  // Control block outranks every flash select
  a_ctrl_over: assert property (
    ctrl_block_sel |-> main_flash_sector_sel == '0 &&
      boot_flash_segment_sel == '0)
    else $error("flash selected over control block");

  // Upper data half always hits a boot segment when boot sits in data
  a_boot_page_free: assert property (
    data_cycle && !fetch_cycle &&
      placement_ff[pmd_pkg::PLC_BF_DATA] && addr[15]
    |-> boot_flash_segment_sel != '0)
    else $error("boot segment missing in upper data half");

  // Main flash placed nowhere must stay silent
  a_mf_needs_place: assert property (
    !placement_ff[pmd_pkg::PLC_MF_PROG] &&
      !placement_ff[pmd_pkg::PLC_MF_DATA]
    |-> main_flash_sector_sel == '0)
    else $error("main flash selected while unplaced");

  // Boot flash placed nowhere must stay silent
  a_bf_needs_place: assert property (
    !placement_ff[pmd_pkg::PLC_BF_PROG] &&
      !placement_ff[pmd_pkg::PLC_BF_DATA]
    |-> boot_flash_segment_sel == '0)
    else $error("boot flash selected while unplaced");

  // SRAM answers a fetch only when placed in program space
  a_sram_fetch_gate: assert property (
    fetch_cycle && !data_cycle &&
      !placement_ff[pmd_pkg::PLC_SRAM_PROG]
    |-> !sram_sel)
    else $error("SRAM selected on a fetch while not placed");

  // SRAM select never leaks past its window
  a_sram_window: assert property (
    sram_sel |-> addr <= pmd_pkg::SRAM_HI)
    else $error("SRAM selected outside its window");

  // Pages beyond the third reach no upper main-flash sector
  a_page_none: assert property (
    fetch_cycle && !data_cycle &&
      placement_ff[pmd_pkg::PLC_MF_PROG] && addr[15] && page > 8'h02
    |-> main_flash_sector_sel == '0)
    else $error("upper sector selected on an unused page");

  // Bottom page of data space is not punched out for internal resources
  a_low_internal: assert property (
    data_cycle && addr[15:8] == 8'h00 |-> sram_sel)
    else $error("SRAM missing under the internal resource range");

  // A write lands in the placement register on the next edge
  a_place_load: assert property (
    placement_wr |=> placement_ff == $past(placement_wdata))
    else $error("placement write did not land");

endmodule
`default_nettype wire

// *** logic/pmd_pkg.sv ***
// Constants for the paged memory address decoder.
// Assumes a 16-bit processor address, an 8-bit page value and one clock.
package pmd_pkg;
  localparam int          ADDR_W       = 16;
  localparam int          PAGE_W       = 8;
  localparam int          MF_SECTORS   = 8;
  localparam int          MF_COMMON    = 2;
  localparam int          BF_SEGMENTS  = 4;
  localparam int          PLACE_W      = 5;
  // Window sizes and bases
  localparam int          MF_SECT_SIZE = 32'h0000_4000;
  localparam int          MF_PAGE_BASE = 32'h0000_8000;
  localparam int          BF_SEG_SIZE  = 32'h0000_2000;
  localparam int          BF_BASE      = 32'h0000_8000;
  localparam logic [15:0] SRAM_LO      = 16'h0000;
  localparam logic [15:0] SRAM_HI      = 16'h1FFF;
  localparam logic [15:0] CTRL_LO      = 16'h2000;
  localparam logic [15:0] CTRL_HI      = 16'h20FF;
  // Placement control bit positions
  localparam int          PLC_SRAM_PROG = 0;
  localparam int          PLC_BF_PROG   = 1;
  localparam int          PLC_MF_PROG   = 2;
  localparam int          PLC_BF_DATA   = 3;
  localparam int          PLC_MF_DATA   = 4;
  // Placement after reset: main flash in program, boot flash in data
  localparam logic [4:0]  PLC_RESET     = 5'h0C;
endpackage

// *** testbench/pmd_host_model.sv ***
// Behavioural processor bus side: address, page register and strobes.
// Assumes the bench hands it one request per cycle on core_clk.
`timescale 1ns/1ps
`default_nettype none
module pmd_host_model
(
  input  wire logic        core_clk,             // Bus clock
  input  wire logic [15:0] req_addr,             // Wanted address
  input  wire logic [7:0]  req_page,             // Wanted page
  input  wire logic [2:0]  req_kind,             // {wr, rd, fetch}
  output logic      [15:0] addr,                 // Bus address
  output logic      [7:0]  page,                 // Page register
  output logic             program_fetch_strobe, // Fetch
  output logic             data_rd_strobe,       // Data read
  output logic             data_wr_strobe        // Data write
);
  // Known levels before the first bus cycle
  initial
  begin
    {addr, page} = 24'h00_0000;
    {data_wr_strobe, data_rd_strobe, program_fetch_strobe} = 3'h0;
  end
  // Idle bus wanders so a stale address never looks valid
  always @(posedge core_clk)
  begin
    {data_wr_strobe, data_rd_strobe, program_fetch_strobe} <= req_kind;
    page <= req_page;
    addr <= (req_kind != 3'h0) ? req_addr : ~addr;
  end
endmodule
`default_nettype wire

// *** testbench/paged_memory_address_decoder_bench.sv ***
// Self-checking bench for the paged memory address decoder.
// Assumes pmd_decoder and pmd_host_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module paged_memory_address_decoder_bench;
  logic core_clk = 1'b0, rst = 1'b1, placement_wr = 1'b0;
  logic [15:0] req_addr = 16'h0000, addr;
  logic [7:0] req_page = 8'h00, page, mf;
  logic [2:0] req_kind = 3'h0;
  logic [4:0] placement_wdata = 5'h00, plc;
  logic [3:0] bf;
  logic fe, rd, wr, ss, cs;
  int bad_count = 0, total_checks = 0;
  initial forever #25 core_clk = ~core_clk;
  pmd_host_model pmd_host_model_i (.core_clk(core_clk), .req_addr(req_addr),
    .req_page(req_page), .req_kind(req_kind), .addr(addr), .page(page),
    .program_fetch_strobe(fe), .data_rd_strobe(rd), .data_wr_strobe(wr));
  pmd_decoder pmd_decoder_i (.core_clk(core_clk), .rst(rst), .addr(addr),
    .page(page), .program_fetch_strobe(fe), .data_rd_strobe(rd),
    .data_wr_strobe(wr), .placement_wr(placement_wr),
    .placement_wdata(placement_wdata), .memory_placement_control(plc),
    .main_flash_sector_sel(mf), .boot_flash_segment_sel(bf),
    .sram_sel(ss), .ctrl_block_sel(cs));
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bits: 13..6 sectors, 5..2 boot segments, 1 SRAM, 0 control block
  function automatic logic [15:0] exp_sel(input logic [15:0] a,
    input logic [7:0] p, input logic [2:0] k, input logic [4:0] c);
    logic f, d, bs, ms;
    logic [15:0] r;
    f = k[0];
    d = k[1] | k[2];
    r = 16'h0000;
    r[1] = (d | (f & c[0])) & (a <= 16'h1FFF);
    r[0] = d & (a >= 16'h2000) & (a <= 16'h20FF);
    bs = ((d & c[3]) | (f & c[1])) & a[15];
    r[5:2] = bs ? (4'h1 << a[14:13]) : 4'h0;
    ms = ((d & c[4]) | (f & c[2])) & !bs & !r[1] & !r[0];
    if (ms & !a[15]) r[6 + a[14]] = 1'b1;
    else if (ms & (p < 8'h03)) r[8 + 2 * p + a[14]] = 1'b1;
    return r;
  endfunction
  // Window edges on every kind of cycle and several pages
  task automatic t_sweep(input logic [4:0] c);
    logic [15:0] al[16] = '{16'h0000, 16'h1FFF, 16'h2000, 16'h20FF,
      16'h2100, 16'h3FFF, 16'h4000, 16'h7FFF, 16'h8000, 16'h9FFF,
      16'hA000, 16'hBFFF, 16'hC000, 16'hDFFF, 16'hE000, 16'hFFFF};
    logic [7:0] pg;
    logic [15:0] e;
    for (int i = 0; i < 64; i++)
      for (int k = 0; k < 8; k++)
      begin
        pg = (i[1:0] == 2'h3) ? 8'h82 : {6'h00, i[1:0]};
        @(posedge core_clk);
        req_addr <= al[i / 4];
        req_page <= pg;
        req_kind <= k[2:0];
        @(posedge core_clk);
        @(negedge core_clk);
        e = exp_sel(al[i / 4], pg, k[2:0], c);
        chk("sectors", {8'h00, mf}, {8'h00, e[13:6]});
        chk("boot", {12'h000, bf}, {12'h000, e[5:2]});
        chk("sram", {15'h0000, ss}, {15'h0000, e[1]});
        chk("control", {15'h0000, cs}, {15'h0000, e[0]});
      end
  endtask
  // Load placement, then decode under it
  task automatic t_place(input logic [4:0] v);
    @(posedge core_clk);
    placement_wr <= 1'b1;
    placement_wdata <= v;
    @(posedge core_clk);
    placement_wr <= 1'b0;
    @(negedge core_clk);
    chk("placement", {11'h000, plc}, {11'h000, v});
    t_sweep(v);
  endtask
  // Reset in mid-run restores the default placement
  task automatic t_reset;
    @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    chk("placement reset", {11'h000, plc}, 16'h000C);
  endtask
  task automatic results;
    if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    chk("placement default", {11'h000, plc}, 16'h000C);
    t_sweep(5'h0C);
    t_place(5'h14);
    t_place(5'h1F);
    t_place(5'h0B);
    t_place(5'h00);
    t_reset;
    results;
  end
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    results;
  end
endmodule
`default_nettype wire
